//--- include/cte_pkg.sv
package cte_pkg;

  // ==========================================================
  // Sizes
  localparam int unsigned NCH = 16;
  localparam int unsigned NTM = 16;
  localparam logic [31:0] CLK_HZ = 32'd40_000_000;
  // One-second timebase, cycles at the system clock
  localparam int unsigned SEC_CYCLES = CLK_HZ * 1;

  // ==========================================================
  // Register port: addr = {field, index}
  localparam logic [3:0] F_COIL = 4'h0;
  localparam logic [3:0] F_TYPE = 4'h1;
  localparam logic [3:0] F_ON_TGT = 4'h2;
  localparam logic [3:0] F_OFF_TGT = 4'h3;
  localparam logic [3:0] F_ON_RDY = 4'h4;
  localparam logic [3:0] F_OFF_RDY = 4'h5;
  localparam logic [3:0] F_ON_RET = 4'h6;
  localparam logic [3:0] F_OFF_RET = 4'h7;
  localparam logic [3:0] F_ON_DUR = 4'h8;
  localparam logic [3:0] F_OFF_DUR = 4'h9;
  localparam logic [3:0] F_TM_DESC = 4'hA;
  localparam logic [3:0] F_TM_HR = 4'hB;
  localparam logic [3:0] F_GLOBAL = 4'hC;
  localparam logic [3:0] G_CRC_POLY = 4'h0;
  localparam logic [3:0] G_STATUS = 4'h1;

  // ==========================================================
  // Reset values
  localparam logic [31:0] DESC_RST = 32'hFF00_0000;
  localparam logic [15:0] CRC_POLY_RST = 16'hA001;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [7:0] DUR_RST = 8'h01;

  // ==========================================================
  // Codes
  localparam logic [15:0] CODE_ON = 16'hFF00;
  localparam logic [15:0] CODE_OFF = 16'h0000;
  localparam logic [7:0] ACC_FREE = 8'h01;
  localparam logic [7:0] ACC_RAISE = 8'h02;
  localparam logic [7:0] SIG_LOW = 8'h00;
  localparam logic [7:0] SIG_HIGH = 8'h01;
  localparam logic [7:0] TM_ABSENT = 8'h80;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [7:0] spec;
    logic [15:0] param;
    logic [7:0] modaddr;
  } cte_desc_s;

  typedef struct packed {
    logic [15:0] coil;
    logic [15:0] code;
  } cte_cmd_s;

  typedef struct packed {
    logic write;
    logic raise;
    logic value;
    logic [15:0] param;
    logic [7:0] modaddr;
  } cte_mbreq_s;

  typedef struct packed {
    logic bit_val;
    logic [7:0] level;
  } cte_mbrsp_s;

  typedef struct packed {
    logic init;
    logic [7:0] data;
  } cte_crc_s;

  typedef enum logic [3:0] {
    CTE_IDLE, CTE_FIND, CTE_LEVEL, CTE_READY, CTE_WRITE,
    CTE_POLL, CTE_WAIT, CTE_CLEAR
  } cte_state_e;

endpackage

//--- verilog/cte_executor.sv
// Function
// - Sixteen command channels, each with descriptors
// - Channel bound to even coil address only
// - Stage digit selects one or two stages
// - Pulse mode writes 1, waits, writes 0
// - Level mode writes commanded value directly
// - Target is parameter number in module
// - Specifier 1 free, 2 raise, else block
// - Refuse when target level exceeds specifier
// - FF00 uses on set, 0000 off set
// - Level channels use only on descriptors
// - Readiness bit gates command, polarity selectable
// - Return bit ends pulse, polarity selectable
// - Separate on/off durations, 1 to 255 s
// - Sixteen telemetry descriptors, 80h or up absent
// - Telemetry entries map to holding addresses
// - CRC-16 with configurable reflected polynomial
`timescale 1ns/10ps
`default_nettype none
module cte_executor #(
  parameter int unsigned TICK_CYCLES = cte_pkg::SEC_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic cmd_valid,
  input wire cte_pkg::cte_cmd_s cmd,
  output logic cmd_ready,
  output logic ans_valid,
  output logic ans_exc,
  output logic mb_req_valid,
  output cte_pkg::cte_mbreq_s mb_req,
  input wire logic mb_ack,
  input wire cte_pkg::cte_mbrsp_s mb_rsp,
  input wire logic hr_valid,
  input wire logic [15:0] hr_addr,
  output logic hr_hit,
  output logic [3:0] hr_index,
  output cte_pkg::cte_desc_s hr_desc,
  input wire logic crc_valid,
  input wire cte_pkg::cte_crc_s crc_in,
  output logic [15:0] crc_value
);
  import cte_pkg::*;

  // ==========================================================
  // Configuration storage
  logic [15:0] coil_ff [NCH];
  logic [7:0] type_ff [NCH];
  cte_desc_s on_tgt_ff [NCH];
  cte_desc_s off_tgt_ff [NCH];
  cte_desc_s on_rdy_ff [NCH];
  cte_desc_s off_rdy_ff [NCH];
  cte_desc_s on_ret_ff [NCH];
  cte_desc_s off_ret_ff [NCH];
  logic [7:0] on_dur_ff [NCH];
  logic [7:0] off_dur_ff [NCH];
  cte_desc_s tm_desc_ff [NTM];
  logic [15:0] tm_hr_ff [NTM];
  logic [15:0] poly_ff;

  cte_state_e state_ff;
  logic [3:0] ch_ff;
  logic pulse_ff;
  logic [NCH-1:0] armed_ff;
  cte_desc_s tgt_ff;
  cte_desc_s rdy_ff;
  cte_desc_s ret_ff;
  logic [7:0] sec_ff;
  logic [31:0] tick_cnt_ff;
  logic tick_ff;
  logic last_exc_ff;

  logic [3:0] widx;
  logic [3:0] wfld;
  assign wfld = reg_addr[7:4];
  assign widx = reg_addr[3:0];

  // Ready or return condition met for a bit read back
  function automatic logic sig_met(input logic [7:0] spec,
                                   input logic b);
    sig_met = (spec == SIG_LOW) ? !b : b;
  endfunction

  // Specifier 0 or 1 means the signal is in use
  function automatic logic sig_used(input logic [7:0] spec);
    sig_used = (spec == SIG_LOW) || (spec == SIG_HIGH);
  endfunction

  // ==========================================================
  // Register writes; descriptor tables per channel
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NCH; i++) begin
        coil_ff[i] <= '0;
        type_ff[i] <= '0;
        on_tgt_ff[i] <= DESC_RST;
        off_tgt_ff[i] <= DESC_RST;
        on_rdy_ff[i] <= DESC_RST;
        off_rdy_ff[i] <= DESC_RST;
        on_ret_ff[i] <= DESC_RST;
        off_ret_ff[i] <= DESC_RST;
        on_dur_ff[i] <= DUR_RST;
        off_dur_ff[i] <= DUR_RST;
        tm_desc_ff[i] <= DESC_RST;
        tm_hr_ff[i] <= '0;
      end
      poly_ff <= CRC_POLY_RST;
    end else if (ce && reg_wr) begin
      unique case (wfld)
        F_COIL: coil_ff[widx] <= reg_wdata[15:0];
        F_TYPE: type_ff[widx] <= reg_wdata[7:0];
        F_ON_TGT: on_tgt_ff[widx] <= reg_wdata;
        F_OFF_TGT: off_tgt_ff[widx] <= reg_wdata;
        F_ON_RDY: on_rdy_ff[widx] <= reg_wdata;
        F_OFF_RDY: off_rdy_ff[widx] <= reg_wdata;
        F_ON_RET: on_ret_ff[widx] <= reg_wdata;
        F_OFF_RET: off_ret_ff[widx] <= reg_wdata;
        F_ON_DUR: on_dur_ff[widx] <= reg_wdata[7:0];
        F_OFF_DUR: off_dur_ff[widx] <= reg_wdata[7:0];
        F_TM_DESC: tm_desc_ff[widx] <= reg_wdata;
        F_TM_HR: tm_hr_ff[widx] <= reg_wdata[15:0];
        F_GLOBAL: begin
          if (widx == G_CRC_POLY) begin
            poly_ff <= reg_wdata[15:0];
          end
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Register reads, data stand one cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (ce) begin
      reg_rdata <= '0;
      if (reg_rd) begin
        unique case (wfld)
          F_COIL: reg_rdata <= {16'h0000, coil_ff[widx]};
          F_TYPE: reg_rdata <= {24'h00_0000, type_ff[widx]};
          F_ON_TGT: reg_rdata <= on_tgt_ff[widx];
          F_OFF_TGT: reg_rdata <= off_tgt_ff[widx];
          F_ON_RDY: reg_rdata <= on_rdy_ff[widx];
          F_OFF_RDY: reg_rdata <= off_rdy_ff[widx];
          F_ON_RET: reg_rdata <= on_ret_ff[widx];
          F_OFF_RET: reg_rdata <= off_ret_ff[widx];
          F_ON_DUR: reg_rdata <= {24'h00_0000, on_dur_ff[widx]};
          F_OFF_DUR: reg_rdata <= {24'h00_0000, off_dur_ff[widx]};
          F_TM_DESC: reg_rdata <= tm_desc_ff[widx];
          F_TM_HR: reg_rdata <= {16'h0000, tm_hr_ff[widx]};
          F_GLOBAL: begin
            if (widx == G_CRC_POLY) begin
              reg_rdata <= {16'h0000, poly_ff};
            end else if (widx == G_STATUS) begin
              // Only channels 0 to 7 fit beside the counters
              reg_rdata <= {armed_ff[7:0], 7'h00, last_exc_ff,
                            sec_ff, ch_ff, 4'(state_ff)};
            end
          end
          default: reg_rdata <= '0;
        endcase
      end
    end
  end

  // ==========================================================
  // Channel search; odd coil addresses never match
  cte_cmd_s cmd_ff;
  logic found;
  logic [3:0] found_ch;
  always_comb begin
    found = 1'b0;
    found_ch = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (!cmd_ff.coil[0] && coil_ff[i] == cmd_ff.coil) begin
        found = 1'b1;
        found_ch = 4'(i);
      end
    end
  end

  logic is_level;
  logic use_on;
  assign is_level = (type_ff[found_ch][3:0] != 4'h0);
  // Level channels always use the switch-on set
  assign use_on = is_level || (cmd_ff.code == CODE_ON);

  // ==========================================================
  // One-second timebase; long count shortened by parameter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (ce) begin
      tick_ff <= 1'b0;
      if (tick_cnt_ff == 32'(TICK_CYCLES - 1)) begin
        tick_cnt_ff <= '0;
        tick_ff <= 1'b1;
      end else begin
        tick_cnt_ff <= tick_cnt_ff + 32'd1;
      end
    end
  end

  // ==========================================================
  // Command sequencer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= CTE_IDLE;
      cmd_ff <= '0;
      ch_ff <= '0;
      pulse_ff <= 1'b0;
      armed_ff <= '0;
      tgt_ff <= DESC_RST;
      rdy_ff <= DESC_RST;
      ret_ff <= DESC_RST;
      sec_ff <= '0;
      cmd_ready <= 1'b0;
      ans_valid <= 1'b0;
      ans_exc <= 1'b0;
      last_exc_ff <= 1'b0;
      mb_req_valid <= 1'b0;
      mb_req <= '0;
    end else if (ce) begin
      ans_valid <= 1'b0;
      unique case (state_ff)
        CTE_IDLE: begin
          cmd_ready <= 1'b1;
          if (cmd_valid && cmd_ready) begin
            cmd_ff <= cmd;
            cmd_ready <= 1'b0;
            state_ff <= CTE_FIND;
          end
        end
        CTE_FIND: begin
          ch_ff <= found_ch;
          pulse_ff <= !is_level;
          tgt_ff <= use_on ? on_tgt_ff[found_ch]
                           : off_tgt_ff[found_ch];
          rdy_ff <= use_on ? on_rdy_ff[found_ch]
                           : off_rdy_ff[found_ch];
          ret_ff <= use_on ? on_ret_ff[found_ch]
                           : off_ret_ff[found_ch];
          sec_ff <= use_on ? on_dur_ff[found_ch]
                           : off_dur_ff[found_ch];
          if (!found || (use_on ? !(on_tgt_ff[found_ch].spec
              inside {ACC_FREE, ACC_RAISE})
              : !(off_tgt_ff[found_ch].spec
              inside {ACC_FREE, ACC_RAISE}))) begin
            ans_valid <= 1'b1;
            ans_exc <= 1'b1;
            last_exc_ff <= 1'b1;
            state_ff <= CTE_IDLE;
          end else if (type_ff[found_ch][7:4] != 4'h0
                       && !armed_ff[found_ch]) begin
            // Preliminary stage only arms the channel
            armed_ff[found_ch] <= 1'b1;
            ans_valid <= 1'b1;
            ans_exc <= 1'b0;
            last_exc_ff <= 1'b0;
            state_ff <= CTE_IDLE;
          end else begin
            armed_ff[found_ch] <= 1'b0;
            mb_req_valid <= 1'b1;
            mb_req <= {1'b0, 1'b0, 1'b0,
                       tgt_param(use_on, found_ch),
                       tgt_mod(use_on, found_ch)};
            state_ff <= CTE_LEVEL;
          end
        end
        CTE_LEVEL: begin
          if (mb_ack) begin
            mb_req_valid <= 1'b0;
            if (mb_rsp.level > tgt_ff.spec) begin
              ans_valid <= 1'b1;
              ans_exc <= 1'b1;
              last_exc_ff <= 1'b1;
              state_ff <= CTE_IDLE;
            end else if (sig_used(rdy_ff.spec)) begin
              mb_req_valid <= 1'b1;
              mb_req <= {1'b0, 1'b0, 1'b0,
                         rdy_ff.param, rdy_ff.modaddr};
              state_ff <= CTE_READY;
            end else begin
              issue_write();
            end
          end
        end
        CTE_READY: begin
          if (mb_ack) begin
            mb_req_valid <= 1'b0;
            if (!sig_met(rdy_ff.spec, mb_rsp.bit_val)) begin
              ans_valid <= 1'b1;
              ans_exc <= 1'b1;
              last_exc_ff <= 1'b1;
              state_ff <= CTE_IDLE;
            end else begin
              issue_write();
            end
          end
        end
        CTE_WRITE: begin
          if (mb_ack) begin
            mb_req_valid <= 1'b0;
            ans_valid <= 1'b1;
            ans_exc <= 1'b0;
            last_exc_ff <= 1'b0;
            state_ff <= pulse_ff ? CTE_WAIT : CTE_IDLE;
          end
        end
        CTE_WAIT: begin
          // Poll the return bit while the duration runs
          if (tick_ff && sec_ff <= 8'd1) begin
            begin_clear();
          end else begin
            if (tick_ff) begin
              sec_ff <= sec_ff - 8'd1;
            end
            if (sig_used(ret_ff.spec)) begin
              mb_req_valid <= 1'b1;
              mb_req <= {1'b0, 1'b0, 1'b0,
                         ret_ff.param, ret_ff.modaddr};
              state_ff <= CTE_POLL;
            end
          end
        end
        CTE_POLL: begin
          if (tick_ff && sec_ff > 8'd1) begin
            sec_ff <= sec_ff - 8'd1;
          end
          if (mb_ack) begin
            mb_req_valid <= 1'b0;
            // A zero count means the time ran out during this read
            if (sig_met(ret_ff.spec, mb_rsp.bit_val) || sec_ff == 8'd0
                || (tick_ff && sec_ff <= 8'd1)) begin
              begin_clear();
            end else begin
              state_ff <= CTE_WAIT;
            end
          end else if (tick_ff && sec_ff <= 8'd1) begin
            sec_ff <= 8'd0; // Expired, finish after this read
          end
        end
        CTE_CLEAR: begin
          if (mb_ack) begin
            mb_req_valid <= 1'b0;
            state_ff <= CTE_IDLE;
          end
        end
        default: state_ff <= CTE_IDLE;
      endcase
    end
  end

  // Target parameter number and module of the chosen set
  function automatic logic [15:0] tgt_param(input logic on,
                                            input logic [3:0] c);
    tgt_param = on ? on_tgt_ff[c].param : off_tgt_ff[c].param;
  endfunction

  function automatic logic [7:0] tgt_mod(input logic on,
                                         input logic [3:0] c);
    tgt_mod = on ? on_tgt_ff[c].modaddr : off_tgt_ff[c].modaddr;
  endfunction

  // Set or level write to the target
  task automatic issue_write();
    mb_req_valid <= 1'b1;
    mb_req <= {1'b1, tgt_ff.spec == ACC_RAISE,
               pulse_ff ? 1'b1 : (cmd_ff.code == CODE_ON),
               tgt_ff.param, tgt_ff.modaddr};
    state_ff <= CTE_WRITE;
  endtask

  // Pulse end: write 0 to the same target
  task automatic begin_clear();
    mb_req_valid <= 1'b1;
    mb_req <= {1'b1, tgt_ff.spec == ACC_RAISE, 1'b0,
               tgt_ff.param, tgt_ff.modaddr};
    sec_ff <= 8'd0;
    state_ff <= CTE_CLEAR;
  endtask

  // ==========================================================
  // Telemetry holding-register lookup, lowest index wins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hr_hit <= 1'b0;
      hr_index <= '0;
      hr_desc <= DESC_RST;
    end else if (ce) begin
      hr_hit <= 1'b0;
      if (hr_valid) begin
        for (int i = NTM - 1; i >= 0; i--) begin
          if (tm_desc_ff[i].spec < TM_ABSENT
              && tm_hr_ff[i] == hr_addr) begin
            hr_hit <= 1'b1;
            hr_index <= 4'(i);
            hr_desc <= tm_desc_ff[i];
          end
        end
      end
    end
  end

  // ==========================================================
  // Byte-serial reflected CRC-16
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0] d,
                                           input logic [15:0] p);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int b = 0; b < 8; b++) begin
      r = r[0] ? ((r >> 1) ^ p) : (r >> 1);
    end
    crc_step = r;
  endfunction

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      crc_value <= CRC_INIT;
    end else if (ce && crc_valid) begin
      crc_value <= crc_step(crc_in.init ? CRC_INIT : crc_value,
                            crc_in.data, poly_ff);
    end
  end

endmodule
`default_nettype wire

//--- test/cte_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Port checker for the command executor
module cte_chk
  import cte_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic ans_valid,
  input wire logic ans_exc,
  input wire logic mb_req_valid,
  input wire cte_pkg::cte_mbreq_s mb_req,
  input wire logic mb_ack,
  input wire logic hr_valid,
  input wire logic hr_hit,
  input wire cte_pkg::cte_desc_s hr_desc,
  input wire logic crc_valid,
  input wire logic [15:0] crc_value
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  logic wr_seen_ff;

  // Any target write since the last take; a refusal must leave it clear
  always_ff @(posedge clk) begin
    if (!rst_n || (cmd_valid && cmd_ready)) begin
      wr_seen_ff <= 1'b0;
    end else if (mb_ack && mb_req_valid && mb_req.write) begin
      wr_seen_ff <= 1'b1;
    end
  end

  sequence take_s;
    cmd_valid && cmd_ready;
  endsequence

  // ==========================================
  // Assertions
  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside its slot");
  answer_bound_a: assert property (
    take_s |-> ##[2:60] ans_valid)
    else $error("command left without answer");
  ans_pulse_a: assert property (
    ans_valid |=> !ans_valid)
    else $error("answer longer than one cycle");
  exc_nowrite_a: assert property (
    ans_valid && ans_exc |-> !wr_seen_ff)
    else $error("refused command wrote its target");
  mb_hold_a: assert property (
    mb_req_valid && !mb_ack |=> mb_req_valid && $stable(mb_req))
    else $error("module request changed before ack");
  busy_ready_a: assert property (
    mb_req_valid |-> !cmd_ready)
    else $error("ready while module bus busy");
  take_drop_a: assert property (
    take_s |=> !cmd_ready [*2])
    else $error("ready right after take");
  hr_cause_a: assert property (
    hr_hit |-> $past(hr_valid))
    else $error("lookup hit without request");
  hr_present_a: assert property (
    hr_hit |-> hr_desc.spec < TM_ABSENT)
    else $error("hit on absent entry");
  crc_hold_a: assert property (
    !crc_valid |=> $stable(crc_value))
    else $error("crc moved without a byte");
endmodule
`default_nettype wire

//--- test/cte_fmod_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Field module bus model
module cte_fmod_model
  import cte_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mb_req_valid,
  input wire cte_pkg::cte_mbreq_s mb_req,
  output logic mb_ack,
  output cte_pkg::cte_mbrsp_s mb_rsp,
  input wire logic [7:0] acc_level,
  input wire logic bit_now,
  input wire logic [1:0] delay,
  output logic [7:0] wr_count,
  output cte_pkg::cte_mbreq_s last_wr
);
  int wait_cnt;

  // Answer after a set delay; slow answers stress the request hold
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mb_ack <= 1'b0;
      mb_rsp <= '0;
      wait_cnt <= 0;
      wr_count <= 8'h00;
      last_wr <= '0;
    end else if (mb_req_valid && !mb_ack && wait_cnt >= int'(delay)) begin
      mb_ack <= 1'b1;
      wait_cnt <= 0;
      mb_rsp <= {bit_now, acc_level};
      if (mb_req.write) begin
        wr_count <= wr_count + 8'h01;
        last_wr <= mb_req;
      end
    end else begin
      mb_ack <= 1'b0;
      wait_cnt <= (mb_req_valid && !mb_ack) ? wait_cnt + 1 : 0;
      mb_rsp <= ~mb_rsp; // Lines mean nothing without ack
    end
  end
endmodule
`default_nettype wire

//--- test/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import cte_pkg::*;
  localparam int TICK = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic cmd_valid = 1'b0;
  cte_cmd_s cmd = '0;
  logic hr_valid = 1'b0;
  logic [15:0] hr_addr = 16'h0000;
  logic crc_valid = 1'b0;
  cte_crc_s crc_in = '0;
  logic [7:0] acc_level = 8'h00;
  logic bit_now = 1'b0;
  logic [1:0] delay = 2'd1;
  logic [31:0] reg_rdata;
  logic cmd_ready, ans_valid, ans_exc, mb_req_valid, mb_ack, hr_hit;
  cte_mbreq_s mb_req, last_wr;
  cte_mbrsp_s mb_rsp;
  logic [3:0] hr_index;
  cte_desc_s hr_desc;
  logic [15:0] crc_value;
  logic [7:0] wr_count;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;

  cte_executor #(.TICK_CYCLES(TICK)) cte_executor_i (.clk, .rst_n, .ce,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cmd_valid, .cmd,
    .cmd_ready, .ans_valid, .ans_exc, .mb_req_valid, .mb_req, .mb_ack,
    .mb_rsp, .hr_valid, .hr_addr, .hr_hit, .hr_index, .hr_desc,
    .crc_valid, .crc_in, .crc_value);
  cte_fmod_model cte_fmod_model_i (.clk, .rst_n, .mb_req_valid, .mb_req,
    .mb_ack, .mb_rsp, .acc_level, .bit_now, .delay, .wr_count, .last_wr);

  // ==========================================
  // Clock and hang guard
  initial begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // ==========================================
  // Shared tasks
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Writes leave one idle edge so strobes never collide
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    chk(reg_rdata, e);
  endtask
  task automatic send(input logic [15:0] c, input logic [15:0] code,
                      input logic e);
    int i;
    i = 0;
    while (cmd_ready !== 1'b1 && i < 400) begin
      @(posedge clk);
      i++;
    end
    cmd <= {c, code};
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    i = 0;
    while (ans_valid !== 1'b1 && i < 100) begin
      @(posedge clk);
      i++;
    end
    chk(ans_valid, 1'b1);
    chk(ans_exc, e);
  endtask
  // Cycles from now until the next target write
  task automatic wait_wr(output int n);
    logic [7:0] w;
    w = wr_count;
    n = 0;
    while (wr_count == w && n < 300) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic cfg(input logic [3:0] ch, input logic [15:0] coil,
    input logic [7:0] ty, input logic [31:0] on_t, input logic [31:0] off_t,
    input logic [31:0] ret, input logic [7:0] dur);
    wr({F_COIL, ch}, {16'h0000, coil});
    wr({F_TYPE, ch}, {24'h00_0000, ty});
    wr({F_ON_TGT, ch}, on_t);
    wr({F_OFF_TGT, ch}, off_t);
    wr({F_ON_RET, ch}, ret);
    wr({F_ON_DUR, ch}, {24'h00_0000, dur});
  endtask
  task automatic look(input logic [15:0] a);
    hr_addr <= a;
    hr_valid <= 1'b1;
    @(posedge clk);
    hr_valid <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [15:0] crc8(input logic [15:0] c,
    input logic [7:0] d, input logic [15:0] p);
    c = c ^ {8'h00, d};
    for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ p : c >> 1;
    return c;
  endfunction

  // ==========================================
  // Scenarios
  task automatic t_regs();
    rd({F_COIL, 4'h0}, 32'h0000_0000);
    rd({F_TYPE, 4'hF}, 32'h0000_0000);
    rd({F_ON_TGT, 4'h7}, DESC_RST);
    rd({F_OFF_DUR, 4'h2}, {24'h00_0000, DUR_RST});
    rd({F_TM_DESC, 4'h9}, DESC_RST);
    rd({F_GLOBAL, G_CRC_POLY}, {16'h0000, CRC_POLY_RST});
    wr(8'hD5, 32'h1234_5678);
    rd(8'hD5, 32'h0000_0000);
    wr({F_ON_RET, 4'hF}, 32'h01AA_BB0C);
    rd({F_ON_RET, 4'hF}, 32'h01AA_BB0C);
    ce <= 1'b0;
    wr({F_ON_RET, 4'hF}, 32'h0000_0000);
    ce <= 1'b1;
    rd({F_ON_RET, 4'hF}, 32'h01AA_BB0C);
    $display("t_regs done");
  endtask
  task automatic t_level();
    logic [7:0] w0;
    cfg(4'h3, 16'h0006, 8'h01, 32'h0112_3405, 32'h0100_BB07, DESC_RST,
        8'h01);
    send(16'h0006, CODE_ON, 1'b0);
    chk(last_wr, {3'b101, 16'h1234, 8'h05});
    send(16'h0006, CODE_OFF, 1'b0);
    chk(last_wr, {3'b100, 16'h1234, 8'h05});
    w0 = wr_count;
    wr({F_ON_TGT, 4'h3}, 32'h0312_3405);
    send(16'h0006, CODE_ON, 1'b1);
    wr({F_ON_TGT, 4'h3}, 32'h0212_3405);
    acc_level <= 8'h03;
    send(16'h0006, CODE_ON, 1'b1);
    wr({F_ON_RDY, 4'h3}, 32'h0100_0101);
    acc_level <= 8'h02;
    send(16'h0006, CODE_ON, 1'b1);
    chk(wr_count, w0);
    bit_now <= 1'b1;
    send(16'h0006, CODE_ON, 1'b0);
    chk(last_wr, {3'b111, 16'h1234, 8'h05});
    wr({F_COIL, 4'h3}, 32'h0000_0007);
    send(16'h0007, CODE_ON, 1'b1);
    $display("t_level done");
  endtask
  task automatic t_pulse();
    int n;
    cfg(4'h5, 16'h000A, 8'h00, 32'h0120_0003, 32'h0130_0004, DESC_RST,
        8'h02);
    acc_level <= 8'h00;
    send(16'h000A, CODE_ON, 1'b0);
    chk(last_wr, {3'b101, 16'h2000, 8'h03});
    wait_wr(n);
    chk(last_wr, {3'b100, 16'h2000, 8'h03});
    chk(n >= TICK && n <= 2 * TICK + 12, 1'b1);
    send(16'h000A, CODE_OFF, 1'b0);
    chk(last_wr, {3'b101, 16'h3000, 8'h04});
    wait_wr(n);
    chk(n <= TICK + 12, 1'b1);
    wr({F_ON_RET, 4'h5}, 32'h0100_4403);
    wr({F_ON_DUR, 4'h5}, 32'h0000_0005);
    delay <= 2'd3;
    send(16'h000A, CODE_ON, 1'b0);
    wait_wr(n);
    chk(n <= 2 * TICK, 1'b1);
    bit_now <= 1'b0;
    send(16'h000A, CODE_ON, 1'b0);
    wait_wr(n);
    chk(n >= 4 * TICK && n <= 6 * TICK, 1'b1);
    $display("t_pulse done");
  endtask
  task automatic t_stage();
    logic [7:0] w0;
    cfg(4'hF, 16'hFFFE, 8'h11, 32'h0155_5501, DESC_RST, DESC_RST, 8'h01);
    w0 = wr_count;
    send(16'hFFFE, CODE_ON, 1'b0);
    chk(wr_count, w0);
    send(16'hFFFE, CODE_ON, 1'b0);
    chk(last_wr, {3'b101, 16'h5555, 8'h01});
    $display("t_stage done");
  endtask
  task automatic t_tm();
    wr({F_TM_DESC, 4'h1}, 32'h8000_1111);
    wr({F_TM_HR, 4'h1}, 32'h0000_0064);
    wr({F_TM_DESC, 4'h2}, 32'h7F00_2222);
    wr({F_TM_HR, 4'h2}, 32'h0000_0064);
    wr({F_TM_DESC, 4'h3}, 32'h0000_3333);
    wr({F_TM_HR, 4'h3}, 32'h0000_0065);
    look(16'h0064);
    chk(hr_index, 4'h2);
    chk(hr_desc, 32'h7F00_2222);
    chk(hr_hit, 1'b1);
    look(16'h0065);
    chk(hr_index, 4'h3);
    look(16'h0066);
    chk(hr_hit, 1'b0);
    $display("t_tm done");
  endtask
  task automatic t_crc(input logic [15:0] p);
    logic [15:0] e;
    e = crc8(crc8(CRC_INIT, 8'h01, p), 8'hA5, p);
    wr({F_GLOBAL, G_CRC_POLY}, {16'h0000, p});
    crc_valid <= 1'b1;
    crc_in <= {1'b1, 8'h01};
    @(posedge clk);
    crc_in <= {1'b0, 8'hA5};
    @(posedge clk);
    crc_valid <= 1'b0;
    @(posedge clk);
    chk(crc_value, e);
    $display("t_crc done");
  endtask

  // ==========================================
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_level();
    t_pulse();
    t_stage();
    t_tm();
    t_crc(CRC_POLY_RST);
    t_crc(16'h8408);
    stop_test();
  end
endmodule

bind cte_executor cte_chk cte_chk_i (.clk, .rst_n, .reg_rd, .reg_rdata,
  .cmd_valid, .cmd_ready, .ans_valid, .ans_exc, .mb_req_valid, .mb_req,
  .mb_ack, .hr_valid, .hr_hit, .hr_desc, .crc_valid, .crc_value);
`default_nettype wire
